//--- include/dog_ctrl_pkg.sv
// constants shared by the reset-cause and watchdog control block
// assumes an 8-bit register port and a free-running watchdog oscillator pin
package dog_ctrl_pkg;
  // register port
  localparam int         ADDR_W          = 2;
  localparam int         DATA_W          = 8;
  localparam logic [1:0] FLAGS_ADDR      = 2'h0;
  localparam logic [1:0] DOG_CTRL_ADDR   = 2'h1;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // reset_cause_flags fields
  localparam int         FLAG_W          = 5;
  localparam int         POWERUP_BIT     = 0;
  localparam int         PIN_BIT         = 1;
  localparam int         BROWNOUT_BIT    = 2;
  localparam int         DOG_BIT         = 3;
  localparam int         DEBUG_BIT       = 4;
  localparam logic [4:0] FLAGS_RESET     = 5'h01;
  localparam logic [4:0] FLAGS_NONE      = 5'h00;

  // watchdog_control fields
  localparam int         PERIOD_W        = 3;
  localparam int         PERIOD_LSB      = 0;
  localparam int         ENABLE_BIT      = 3;
  localparam int         UNLOCK_BIT      = 4;
  localparam logic [2:0] RESERVED_ZERO   = 3'h0;
  localparam logic [2:0] PERIOD_RESET    = 3'h0;

  // unlock window, in system clock cycles
  localparam int         WIN_W           = 3;
  localparam logic [2:0] UNLOCK_CYCLES   = 3'h4;
  localparam logic [2:0] WIN_LAST        = 3'h1;
  localparam logic [2:0] WIN_IDLE        = 3'h0;

  // watchdog oscillator count: 16K cycles at period code zero
  localparam int         DOG_CNT_W       = 22;
  localparam int         DOG_BASE_CYCLES = 16384;

  // synchronised input lanes
  localparam int         SYNC_W          = 5;
  localparam int         LANE_FUSE       = 0;
  localparam int         LANE_OSC        = 1;
  localparam int         LANE_PIN        = 2;
  localparam int         LANE_BROWNOUT   = 3;
  localparam int         LANE_DEBUG      = 4;
endpackage

//--- verilog/sync_two_flop.sv
// two-flop synchroniser for a bundle of independent levels
// assumes each lane is a slow level; lanes are not coherent with one another
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

//--- verilog/dog_counter.sv
// watchdog oscillator edge counter with selectable timeout
// assumes i_osc is already synchronised to i_clk and runs much slower
`timescale 1ns/1ps
module dog_counter
  import dog_ctrl_pkg::*;
#(
  parameter int BASE_CYCLES = DOG_BASE_CYCLES
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_osc,
  input  wire logic                i_enable,
  input  wire logic                i_clear,
  input  wire logic [PERIOD_W-1:0] i_period_sel,
  output logic                     o_expire
);
  logic                 osc_prev;
  logic [DOG_CNT_W-1:0] count;
  logic [DOG_CNT_W-1:0] next_count;
  logic                 next_expire;
  logic [DOG_CNT_W-1:0] limit;
  logic                 tick;

  // each period code doubles the count
  assign limit = DOG_CNT_W'(BASE_CYCLES) << i_period_sel;
  assign tick  = i_osc && !osc_prev;

  // kick, disable or chip reset restart the count
  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (i_clear || !i_enable) begin
      next_count = '0;
    end else if (tick) begin
      if (count == limit - DOG_CNT_W'(1)) begin
        next_count  = '0;
        next_expire = 1'b1;
      end else begin
        next_count = count + DOG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_prev <= 1'b0;
      count    <= '0;
      o_expire <= 1'b0;
    end else begin
      osc_prev <= i_osc;
      count    <= next_count;
      o_expire <= next_expire;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_expire_single_cycle: assert property (o_expire |=> !o_expire)
    else $error("timeout pulse longer than one cycle");
  chk_clear_restarts: assert property (i_clear |=> count == '0)
    else $error("count not restarted by clear");
  chk_expire_needs_enable: assert property (o_expire |-> $past(i_enable))
    else $error("timeout while disabled");
endmodule

//--- verilog/reset_cause_and_watchdog_ctrl.sv
// reset-cause flags and watchdog control register with timed unlock
// assumes reset request levels, fuse and oscillator arrive asynchronously;
// i_rst_n is the power-on reset; i_dog_kick comes from logic on i_clk
//
// Overview of operation
// - debug-port reset sets flag bit 4
// - watchdog reset sets flag bit 3
// - brown-out reset sets flag bit 2
// - pin reset sets flag bit 1
// - power-on sets bit 0; only software clears
// - control bits 7 to 5 read zero
// - unlock bit self-clears four cycles later
// - enable clears only while unlock reads one
// - one enables watchdog; permitted zero disables
// - safety level 2 never disables watchdog
// - period code gives 16K doubling to 2048K
// - level 2 keeps enabled, reads one
// - level 1 starts disabled, enable anytime
// - kick, disable, chip reset restart count
// - timeout gives one-cycle reset pulse
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module reset_cause_and_watchdog_ctrl
  import dog_ctrl_pkg::*;
#(
  parameter int BASE_CYCLES = DOG_BASE_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic              i_pin_reset_req,
  input  wire logic              i_brownout_req,
  input  wire logic              i_debug_reset_req,
  input  wire logic              i_dog_lock_fuse,
  input  wire logic              i_dog_osc,
  input  wire logic              i_dog_kick,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_dog_reset,
  output logic                   o_dog_active
);
  // synchronised inputs
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_in;
  logic              fuse_level2;
  logic              osc_sync;
  logic              pin_req;
  logic              brownout_req;
  logic              debug_req;

  // register state
  logic [FLAG_W-1:0]   flags;
  logic [FLAG_W-1:0]   next_flags;
  logic                unlock;
  logic                next_unlock;
  logic [WIN_W-1:0]    win_cnt;
  logic [WIN_W-1:0]    next_win_cnt;
  logic                enable;
  logic                next_enable;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] next_period;
  logic [DATA_W-1:0]   next_rdata;
  logic                next_dog_active;

  // decoded strobes and events
  logic                flags_wr;
  logic                dog_wr;
  logic                open_req;
  logic                chip_reset;
  logic                eff_enable;
  logic                dog_expire;
  logic                dog_clear;
  logic [FLAG_W-1:0]   flag_set;
  logic [FLAG_W-1:0]   flag_clr;

  // one decoder shared by write and read paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

  // every asynchronous level passes two flops before use
  assign async_in[LANE_FUSE]     = i_dog_lock_fuse;
  assign async_in[LANE_OSC]      = i_dog_osc;
  assign async_in[LANE_PIN]      = i_pin_reset_req;
  assign async_in[LANE_BROWNOUT] = i_brownout_req;
  assign async_in[LANE_DEBUG]    = i_debug_reset_req;

  sync_two_flop #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (async_in),
    .o_sync  (sync_in)
  );

  assign fuse_level2  = sync_in[LANE_FUSE];
  assign osc_sync     = sync_in[LANE_OSC];
  assign pin_req      = sync_in[LANE_PIN];
  assign brownout_req = sync_in[LANE_BROWNOUT];
  assign debug_req    = sync_in[LANE_DEBUG];

  // strobes and chip-level reset
  assign flags_wr   = i_wr && addr_hit(i_addr, FLAGS_ADDR);
  assign dog_wr     = i_wr && addr_hit(i_addr, DOG_CTRL_ADDR);
  // window opens only when unlock and enable are written together
  assign open_req   = dog_wr && i_wdata[UNLOCK_BIT] && i_wdata[ENABLE_BIT];
  assign chip_reset = pin_req || brownout_req || debug_req || dog_expire;
  // the fuse overrides the stored bit, so level 2 cannot be turned off
  assign eff_enable = enable || fuse_level2;
  assign dog_clear  = i_dog_kick || chip_reset;

  // ---- reset-cause flags ----
  // set terms from each reset source; powerup is only set by i_rst_n
  always_comb begin
    flag_set               = FLAGS_NONE;
    flag_set[DEBUG_BIT]    = debug_req;
    flag_set[DOG_BIT]      = dog_expire;
    flag_set[BROWNOUT_BIT] = brownout_req;
    flag_set[PIN_BIT]      = pin_req;
  end

  // a written zero clears, a written one is ignored; set beats clear
  always_comb begin
    flag_clr   = flags_wr ? ~i_wdata[FLAG_W-1:0] : FLAGS_NONE;
    next_flags = (flags & ~flag_clr) | flag_set;
  end

  // power-on reset leaves only the powerup flag standing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ---- watchdog control ----
  always_comb begin
    next_unlock  = unlock;
    next_win_cnt = win_cnt;
    next_enable  = enable;
    next_period  = period;
    if (chip_reset) begin
      // stored bits return to the level 1 start state
      next_unlock  = 1'b0;
      next_win_cnt = WIN_IDLE;
      next_enable  = 1'b0;
      next_period  = PERIOD_RESET;
    end else if (open_req) begin
      // open or reopen the window; enable is set to one
      next_unlock  = 1'b1;
      next_win_cnt = UNLOCK_CYCLES;
      next_enable  = 1'b1;
    end else if (dog_wr) begin
      // second step: a write with unlock low closes the window
      next_unlock  = 1'b0;
      next_win_cnt = WIN_IDLE;
      if (i_wdata[ENABLE_BIT]) begin
        next_enable = 1'b1;
      end else if (unlock && !fuse_level2) begin
        next_enable = 1'b0;
      end
      if (unlock) begin
        next_period = i_wdata[PERIOD_LSB +: PERIOD_W];
      end
    end else if (unlock) begin
      // window times out after four cycles with no write
      next_win_cnt = win_cnt - WIN_LAST;
      if (win_cnt == WIN_LAST) begin
        next_unlock = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlock  <= 1'b0;
      win_cnt <= WIN_IDLE;
      enable  <= 1'b0;
      period  <= PERIOD_RESET;
    end else begin
      unlock  <= next_unlock;
      win_cnt <= next_win_cnt;
      enable  <= next_enable;
      period  <= next_period;
    end
  end

  // ---- timeout counter ----
  // expire is a flop inside the counter, so the pulse leaves glitch-free
  dog_counter #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_counter (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_osc        (osc_sync),
    .i_enable     (eff_enable),
    .i_clear      (dog_clear),
    .i_period_sel (period),
    .o_expire     (dog_expire)
  );

  assign o_dog_reset = dog_expire;

  // ---- read port ----
  // read data stand in the cycle after the strobe only
  always_comb begin
    next_rdata      = READ_ZERO;
    next_dog_active = eff_enable;
    if (i_rd) begin
      if (addr_hit(i_addr, FLAGS_ADDR)) begin
        next_rdata[FLAG_W-1:0] = flags;
      end else if (addr_hit(i_addr, DOG_CTRL_ADDR)) begin
        next_rdata[UNLOCK_BIT]                  = unlock;
        next_rdata[ENABLE_BIT]                  = eff_enable;
        next_rdata[PERIOD_LSB +: PERIOD_W]      = period;
        next_rdata[DATA_W-1:UNLOCK_BIT+1]           = RESERVED_ZERO;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata      <= READ_ZERO;
      o_dog_active <= 1'b0;
    end else begin
      o_rdata      <= next_rdata;
      o_dog_active <= next_dog_active;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence open_seq;
    open_req && !chip_reset;
  endsequence

  sequence quiet4_seq;
    (!i_wr && !chip_reset)[*4];
  endsequence

  // each source leaves its flag the cycle after it is seen
  chk_debug_flag_set: assert property (debug_req |=> flags[DEBUG_BIT])
    else $error("debug reset flag not set");
  chk_dog_flag_set: assert property (dog_expire |=> flags[DOG_BIT])
    else $error("watchdog flag not set");
  chk_brown_flag_set: assert property (brownout_req |=> flags[BROWNOUT_BIT])
    else $error("brown-out flag not set");
  chk_pin_flag_set: assert property (pin_req |=> flags[PIN_BIT])
    else $error("pin reset flag not set");

  // the powerup flag answers only to power-on and to software
  chk_powerup_kept: assert property (
    flags[POWERUP_BIT] && !(flags_wr && !i_wdata[POWERUP_BIT]) |=> flags[POWERUP_BIT])
    else $error("powerup flag lost without a write");
  chk_powerup_cleared: assert property (
    flags_wr && !i_wdata[POWERUP_BIT] |=> !flags[POWERUP_BIT])
    else $error("powerup flag not cleared by a written zero");

  // reserved control bits never leak onto the read port
  chk_reserved_read_zero: assert property (
    i_rd && addr_hit(i_addr, DOG_CTRL_ADDR) |=> o_rdata[DATA_W-1:UNLOCK_BIT+1] == '0)
    else $error("reserved control bits not zero");

  // window open for four quiet cycles, shut on the fifth
  chk_unlock_held: assert property (open_seq ##1 (!i_wr && !chip_reset)[*3] |=> unlock)
    else $error("unlock closed too early");
  chk_unlock_timeout: assert property (open_seq ##1 quiet4_seq |=> !unlock)
    else $error("unlock not cleared after four cycles");
  // a write with unlock low ends the window at once
  chk_write_closes: assert property (
    dog_wr && !open_req && !chip_reset |=> !unlock)
    else $error("window left open after a closing write");

  // enable may rise at any time but falls only inside the window
  chk_enable_guarded: assert property (
    dog_wr && !i_wdata[ENABLE_BIT] && !unlock && enable && !chip_reset |=> enable)
    else $error("enable cleared without unlock");
  chk_window_disable: assert property (
    dog_wr && !i_wdata[ENABLE_BIT] && unlock && !fuse_level2 && !chip_reset |=> !enable)
    else $error("disable refused inside the window");
  chk_enable_anytime: assert property (
    dog_wr && i_wdata[ENABLE_BIT] && !chip_reset |=> enable)
    else $error("enable write not taken");

  // the fuse keeps the watchdog running whatever was stored
  chk_level2_reads_one: assert property (
    fuse_level2 && i_rd && addr_hit(i_addr, DOG_CTRL_ADDR) |=> o_rdata[ENABLE_BIT])
    else $error("level 2 enable read as zero");
  chk_level2_stays_on: assert property (
    fuse_level2 |=> o_dog_active)
    else $error("watchdog inactive in safety level 2");

  // period changes only through the window; chip reset restores defaults
  chk_period_locked: assert property (
    dog_wr && !unlock && !chip_reset |=> period == $past(period))
    else $error("period changed outside window");
  chk_chip_reset_clears: assert property (
    chip_reset |=> !enable && !unlock && period == PERIOD_RESET)
    else $error("control not cleared by chip reset");
endmodule

//--- bench/reset_cause_and_watchdog_ctrl_tb.sv
// self-checking bench for the reset-cause flags and watchdog control block
// assumes one 250 MHz clock; oscillator, fuse and reset requests come from here
`timescale 1ns/1ps
module reset_cause_and_watchdog_ctrl_tb;
  import dog_ctrl_pkg::*;
  localparam int BASE  = 4;      // short base count keeps every timeout brief
  localparam int LIMIT = 40000;  // well above the longest expected run
  logic              i_clk           = 1'b0;
  logic              i_rst_n         = 1'b0;
  logic [ADDR_W-1:0] i_addr          = '0;
  logic [DATA_W-1:0] i_wdata         = '0;
  logic              i_wr            = 1'b0;
  logic              i_rd            = 1'b0;
  logic [2:0]        req             = 3'h0;
  logic              i_dog_lock_fuse = 1'b0;
  logic              i_dog_osc       = 1'b0;
  logic              i_dog_kick      = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic              o_dog_reset;
  logic              o_dog_active;
  int                bad_count  = 0;
  int                n_compared = 0;
  int                cycles     = 0;
  int                pulses     = 0;
  int                run        = 0;
  int                widest     = 0;
  logic [31:0]       seed       = 32'h8557;

  reset_cause_and_watchdog_ctrl #(.BASE_CYCLES(BASE)) u_dut (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .i_pin_reset_req   (req[0]),
    .i_brownout_req    (req[1]),
    .i_debug_reset_req (req[2]),
    .i_dog_lock_fuse   (i_dog_lock_fuse),
    .i_dog_osc         (i_dog_osc),
    .i_dog_kick        (i_dog_kick),
    .o_rdata           (o_rdata),
    .o_dog_reset       (o_dog_reset),
    .o_dog_active      (o_dog_active)
  );

  always #2 i_clk = ~i_clk;

  // pulse counter and width tracker; also cuts a hang short
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (o_dog_reset === 1'b1) begin
      run = run + 1;
      if (run == 1) pulses = pulses + 1;
      if (run > widest) widest = run;
    end else begin
      run = 0;
    end
    if (cycles == LIMIT) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // oscillator edges that one timeout needs for a period code
  function automatic int dog_edges(input int p);
    return BASE << p;
  endfunction

  // flag bit that each reset request should leave behind
  function automatic logic [7:0] src_flag(input int k);
    int b;
    b = (k == 0) ? PIN_BIT : (k == 1) ? BROWNOUT_BIT : DEBUG_BIT;
    return 8'h01 << b;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just then
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // slow oscillator: eight system cycles per period
  task automatic osc(input int n);
    repeat (n) begin
      idle(4);
      i_dog_osc <= 1'b1;
      idle(4);
      i_dog_osc <= 1'b0;
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    idle(6);
    i_rst_n <= 1'b1;
    idle(3);
    rchk(FLAGS_ADDR, 8'h01);
    rchk(DOG_CTRL_ADDR, 8'h00);
    chk({7'h00, o_dog_active}, 8'h00);
    // unmapped places ignore random writes and read zero
    for (int i = 0; i < 4; i++) begin
      seed = next_rand(seed);
      wr({1'b1, seed[0]}, seed[15:8]);
      rchk({1'b1, seed[1]}, 8'h00);
    end
    wr(FLAGS_ADDR, 8'hff);
    rchk(FLAGS_ADDR, 8'h01);
    wr(FLAGS_ADDR, 8'hfe);
    rchk(FLAGS_ADDR, 8'h00);
    // each reset request sets its own flag and clears the control register
    for (int k = 0; k < 3; k++) begin
      wr(DOG_CTRL_ADDR, 8'h08);
      req <= 3'h1 << k;
      idle(4);
      req <= 3'h0;
      idle(4);
      rchk(FLAGS_ADDR, src_flag(k));
      rchk(DOG_CTRL_ADDR, 8'h00);
      seed = next_rand(seed);
      wr(FLAGS_ADDR, seed[7:0] & ~src_flag(k));
      rchk(FLAGS_ADDR, 8'h00);
    end
    // enable without unlock; period and reserved bits must not stick
    wr(DOG_CTRL_ADDR, 8'hed);
    rchk(DOG_CTRL_ADDR, 8'h08);
    chk({7'h00, o_dog_active}, 8'h01);
    wr(DOG_CTRL_ADDR, 8'h00);
    rchk(DOG_CTRL_ADDR, 8'h08);
    wr(DOG_CTRL_ADDR, 8'h10);
    wr(DOG_CTRL_ADDR, 8'h00);
    rchk(DOG_CTRL_ADDR, 8'h08);
    // window stays open through the fourth cycle, then closes by itself
    wr(DOG_CTRL_ADDR, 8'h18);
    rchk(DOG_CTRL_ADDR, 8'h18);
    rchk(DOG_CTRL_ADDR, 8'h18);
    rchk(DOG_CTRL_ADDR, 8'h08);
    wr(DOG_CTRL_ADDR, 8'h18);
    wr(DOG_CTRL_ADDR, 8'h00);
    rchk(DOG_CTRL_ADDR, 8'h00);
    idle(1);
    #1;
    chk({7'h00, o_dog_active}, 8'h00);
    // a disable write that comes too late is refused
    wr(DOG_CTRL_ADDR, 8'h08);
    wr(DOG_CTRL_ADDR, 8'h18);
    idle(4);
    wr(DOG_CTRL_ADDR, 8'h00);
    rchk(DOG_CTRL_ADDR, 8'h08);
    wr(DOG_CTRL_ADDR, 8'h18);
    wr(DOG_CTRL_ADDR, 8'h0b);
    rchk(DOG_CTRL_ADDR, 8'h0b);
    wr(DOG_CTRL_ADDR, 8'h0d);
    rchk(DOG_CTRL_ADDR, 8'h0b);
    wr(DOG_CTRL_ADDR, 8'h18);
    wr(DOG_CTRL_ADDR, 8'h00);
    // fuse set: always enabled, yet the period may still change
    i_dog_lock_fuse <= 1'b1;
    idle(4);
    rchk(DOG_CTRL_ADDR, 8'h08);
    chk({7'h00, o_dog_active}, 8'h01);
    wr(DOG_CTRL_ADDR, 8'h18);
    wr(DOG_CTRL_ADDR, 8'h00);
    rchk(DOG_CTRL_ADDR, 8'h08);
    chk({7'h00, o_dog_active}, 8'h01);
    wr(DOG_CTRL_ADDR, 8'h18);
    wr(DOG_CTRL_ADDR, 8'h02);
    rchk(DOG_CTRL_ADDR, 8'h0a);
    @(posedge i_clk);
    i_dog_lock_fuse <= 1'b0;
    idle(4);
    // timeout per period code, with a kick at a random point first
    for (int p = 0; p < 8; p++) begin
      wr(FLAGS_ADDR, 8'h00);
      wr(DOG_CTRL_ADDR, 8'h18);
      wr(DOG_CTRL_ADDR, 8'h08 | {5'h00, p[2:0]});
      seed = next_rand(seed);
      osc((int'(seed[15:0]) % (dog_edges(p) - 1)) + 1);
      @(posedge i_clk);
      i_dog_kick <= 1'b1;
      @(posedge i_clk);
      i_dog_kick <= 1'b0;
      osc(dog_edges(p) - 1);
      idle(8);
      chk(8'(pulses), 8'h00);
      osc(1);
      idle(8);
      chk(8'(pulses), 8'h01);
      chk(8'(widest), 8'h01);
      rchk(FLAGS_ADDR, 8'h08);
      rchk(DOG_CTRL_ADDR, 8'h00);
      pulses = 0;
      widest = 0;
    end
    // power-on reset in mid-run clears the cause flags and sets power-up
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    idle(2);
    i_rst_n <= 1'b1;
    idle(3);
    rchk(FLAGS_ADDR, 8'h01);
    rchk(DOG_CTRL_ADDR, 8'h00);
    conclude();
  end
endmodule
